// [inc/rirq_bank_if.sv]
`timescale 1ns/1ps
interface rirq_bank_if #(parameter int W = 7);
   logic wr;
   logic set_mode;
   logic [W-1:0] sel;
   logic [W-1:0] evt;
   logic [W-1:0] flags;
   modport bank (input wr, input set_mode, input sel, input evt, output flags);
   modport ctl (output wr, output set_mode, output sel, output evt, input flags);
endinterface

// [inc/rirq_defs.svh]
// Operation
// - Writes to second flag register set or clear bits 5..0 per written bit 7.
// - Any-enabled-event flag, second flag register bit 6, follows any enabled active flag.
// - Card detection finding a card sets second flag register bit 5.
// - Timer n underflow sets second flag register bit n, n from 0 to 4.
// - First enable bits 6..0 pass or block first-bank flags toward the global flag.
// - First enable bit 7 inverts the interrupt pin level.
// - Second enable bits 5..0 pass or block card and timer flags.
// - Interrupt pin follows the global flag only while second enable bit 6 is set.
// - Second enable bit 7 selects push-pull, otherwise open-drain pin drive.
// - Eight-bit hardware-updated error status register at address 0x0a.
// - First flag register bits 6..0 use the same set/clear write mechanism.
// - Newly set write-busy, overrun, protocol, empty or integrity error sets first-bank bit 1.
`ifndef RIRQ_DEFS_SVH
`define RIRQ_DEFS_SVH
`define RIRQ_ADDR_FLAGS0 8'h06
`define RIRQ_ADDR_FLAGS1 8'h07
`define RIRQ_ADDR_EN0 8'h08
`define RIRQ_ADDR_EN1 8'h09
`define RIRQ_ADDR_ERR 8'h0a
`define RIRQ_B0_W 7
`define RIRQ_B1_W 6
`define RIRQ_TIMERS 5
`define RIRQ_SET_BIT 7
`define RIRQ_GLOBAL_BIT 6
`define RIRQ_CARD_BIT 5
`define RIRQ_INV_BIT 7
`define RIRQ_PIN_GATE_BIT 6
`define RIRQ_DRIVE_BIT 7
`define RIRQ_ERR_EVT_BIT 1
`define RIRQ_ERR_EVT_MASK 8'h6b
`define RIRQ_RST_BYTE 8'h00
`endif

// [inc/rirq_pkg.sv]
`include "rirq_defs.svh"
package rirq_pkg;
   typedef logic [7:0] rirq_byte_t;
   typedef logic [`RIRQ_B0_W-1:0] rirq_bank0_t;
   typedef logic [`RIRQ_B1_W-1:0] rirq_bank1_t;
   typedef logic [`RIRQ_TIMERS-1:0] rirq_timer_t;
endpackage

// [sim/rirq_pin_pullup.sv]
`timescale 1ns/1ps
module rirq_pin_pullup (
   input wire logic drive_in,
   input wire logic oe_n_in,
   output logic pad_out
);
   // Released line is pulled high
   assign pad_out = oe_n_in ? 1'b1 : drive_in;
endmodule // rirq_pin_pullup

// [sim/rirq_top_props.sv]
`timescale 1ns/1ps
module rirq_top_props (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [4:0] timer_underflow_in,
   input wire logic [7:0] err_set_in,
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe_n_out
);
   logic [7:0] shadow_en0;
   logic [7:0] shadow_en1;

   // Shadow copies of both enable registers, rebuilt from the write port
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         shadow_en0 <= 8'h00;
         shadow_en1 <= 8'h00;
      end else begin
         if (reg_wr_in && reg_addr_in == 8'h08) begin
            shadow_en0 <= reg_wdata_in;
         end
         if (reg_wr_in && reg_addr_in == 8'h09) begin
            shadow_en1 <= reg_wdata_in;
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved");
   chk_pin_released: assert property ($fell(rst_in) |-> irq_pin_oe_n_out && !irq_pin_out)
      else $error("pin not released");
   chk_unmapped_zero: assert property (reg_rd_in && (reg_addr_in < 8'h06 ||
      reg_addr_in > 8'h0a) |=> reg_rdata_out == 8'h00) else $error("unmapped read");
   chk_set1_reads0: assert property (reg_rd_in && reg_addr_in == 8'h07
      |=> !reg_rdata_out[7]) else $error("bit7 of 07");
   chk_set0_reads0: assert property (reg_rd_in && reg_addr_in == 8'h06
      |=> !reg_rdata_out[7]) else $error("bit7 of 06");
   chk_timer_flag: assert property ((timer_underflow_in != 5'h00) ##1
      (reg_rd_in && reg_addr_in == 8'h07) |=> (reg_rdata_out[4:0] &
      $past(timer_underflow_in, 2)) == $past(timer_underflow_in, 2)) else $error("timer flag");
   chk_err_flag: assert property ((err_set_in != 8'h00) ##1
      (reg_rd_in && reg_addr_in == 8'h0a) |=> (reg_rdata_out & $past(err_set_in, 2))
      == $past(err_set_in, 2)) else $error("error flag");
   chk_od_level: assert property (!$past(shadow_en1[7]) && !irq_pin_oe_n_out
      |-> irq_pin_out == !$past(shadow_en0[7])) else $error("open drain level");
   chk_gate_closed: assert property (!shadow_en1[6] |=>
      irq_pin_out == $past(shadow_en0[7]) && irq_pin_oe_n_out == !$past(shadow_en1[7]))
      else $error("pin active while gate closed");
   chk_push_pull: assert property (shadow_en1[7] |=> !irq_pin_oe_n_out)
      else $error("push-pull pin released");
endmodule // rirq_top_props
bind rirq_top rirq_top_props i_props (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .timer_underflow_in, .err_set_in, .irq_pin_out,
   .irq_pin_oe_n_out);

// [sim/tb_rirq_top.sv]
`timescale 1ns/1ps
module tb_rirq_top;
   logic clk_in = 0, rst_in = 1, wr = 0, rd = 0, card = 0, pin, oe_n, lvl, pad;
   logic [7:0] addr = 0, wdata = 0, err_set = 0, err_clr = 0, rdata;
   logic [5:0] ev0 = 0;
   logic [4:0] tmr = 0;
   int err_total = 0, comparisons = 0;
   rirq_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .rx_sof_event_in(ev0[0]), .rx_done_event_in(ev0[1]), .tx_done_event_in(ev0[2]),
      .idle_event_in(ev0[3]), .fill_low_event_in(ev0[4]), .fill_high_event_in(ev0[5]),
      .card_presence_event_in(card), .timer_underflow_in(tmr), .err_set_in(err_set),
      .err_clr_in(err_clr), .irq_pin_in(pad), .irq_pin_out(pin),
      .irq_pin_oe_n_out(oe_n), .irq_pin_level_out(lvl));
   rirq_pin_pullup i_pad (.drive_in(pin), .oe_n_in(oe_n), .pad_out(pad));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1;
      cyc(1);
      wr = 0;
      cyc(1);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1;
      cyc(1);
      rd = 0;
      check(rdata, exp);
      cyc(1);
   endtask
   task automatic pulse(input int i);
      if (i < 5) tmr[i] = 1;
      else card = 1;
      cyc(1);
      tmr = 0;
      card = 0;
   endtask
   task automatic eset(input logic [7:0] s, input logic [7:0] c);
      err_set = s;
      err_clr = c;
      cyc(1);
      err_set = 0;
      err_clr = 0;
   endtask
   task automatic pchk(input logic p, input logic o);
      cyc(6);
      check({5'h00, lvl, oe_n, pin}, {5'h00, o | p, o, p});
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #1000000;
      err_total++;
      print_verdict();
   end
   initial begin
      cyc(20);
      rst_in = 0;
      cyc(1);
      for (int a = 6; a <= 10; a++) rchk(8'(a), 8'h00);
      ev0 = 6'h3f;
      cyc(1);
      ev0 = 0;
      rchk(8'h06, 8'h7d);
      wreg(8'h06, 8'h7f);
      rchk(8'h06, 8'h00);
      wreg(8'h06, 8'h85);
      rchk(8'h06, 8'h05);
      wreg(8'h06, 8'h04);
      rchk(8'h06, 8'h01);
      wreg(8'h07, 8'hbf);
      rchk(8'h07, 8'h3f);
      wreg(8'h07, 8'h15);
      rchk(8'h07, 8'h2a);
      wreg(8'h08, 8'h01);
      rchk(8'h07, 8'h6a);
      wreg(8'h08, 8'h02);
      rchk(8'h07, 8'h2a);
      for (int i = 0; i < 6; i++) begin
         wreg(8'h07, 8'h3f);
         wreg(8'h09, 8'(1 << i));
         pulse(i);
         rchk(8'h07, 8'h40 | 8'(1 << i));
      end
      pchk(0, 1);
      wreg(8'h09, 8'h60);
      pchk(1, 0);
      wreg(8'h08, 8'h80);
      pchk(0, 0);
      wreg(8'h09, 8'he0);
      wreg(8'h07, 8'h3f);
      pchk(1, 0);
      wreg(8'h09, 8'h60);
      pchk(1, 1);
      pulse(0);
      rchk(8'h07, 8'h01);
      tmr = 5'h02;
      addr = 8'h07;
      wdata = 8'h02;
      wr = 1;
      cyc(1);
      tmr = 0;
      wr = 0;
      cyc(1);
      rchk(8'h07, 8'h03);
      wreg(8'h06, 8'h7f);
      eset(8'h84, 8'h00);
      rchk(8'h0a, 8'h84);
      rchk(8'h06, 8'h00);
      eset(8'h02, 8'h00);
      rchk(8'h06, 8'h02);
      eset(8'h01, 8'h01);
      rchk(8'h0a, 8'h87);
      eset(8'h00, 8'hff);
      wreg(8'h0a, 8'hff);
      rchk(8'h0a, 8'h00);
      rchk(8'h20, 8'h00);
      print_verdict();
   end
endmodule // tb_rirq_top

// [src/rirq_flag_bank.sv]
`timescale 1ns/1ps
module rirq_flag_bank #(parameter int W = 7) (
   input wire logic clk_in,
   input wire logic rst_in,
   rirq_bank_if.bank bus
);
   logic [W-1:0] flags;
   logic [W-1:0] next_flags;

   // Hardware events win over a software clear in the same cycle
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign next_flags[i] = bus.evt[i]
         | (bus.wr & bus.set_mode & bus.sel[i])
         | (flags[i] & ~(bus.wr & ~bus.set_mode & bus.sel[i]));
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

   assign bus.flags = flags;
endmodule // rirq_flag_bank

// [src/rirq_top.sv]
`timescale 1ns/1ps
`include "rirq_defs.svh"
module rirq_top
   import rirq_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic rx_sof_event_in,
   input wire logic rx_done_event_in,
   input wire logic tx_done_event_in,
   input wire logic idle_event_in,
   input wire logic fill_low_event_in,
   input wire logic fill_high_event_in,
   input wire logic card_presence_event_in,
   input wire logic [4:0] timer_underflow_in,
   input wire logic [7:0] err_set_in,
   input wire logic [7:0] err_clr_in,
   input wire logic irq_pin_in,
   output logic irq_pin_out,
   output logic irq_pin_oe_n_out,
   output logic irq_pin_level_out
);
   rirq_bank_if #(.W(`RIRQ_B0_W)) bank0 ();
   rirq_bank_if #(.W(`RIRQ_B1_W)) bank1 ();

   rirq_byte_t en0;
   rirq_byte_t next_en0;
   rirq_byte_t en1;
   rirq_byte_t next_en1;
   rirq_byte_t err;
   rirq_byte_t next_err;
   logic global_flag;
   rirq_byte_t next_rdata;
   logic pin_meta;
   logic pin_sync;
   logic next_pin;
   logic next_pin_oe_n;
   logic gated_req;
   logic err_event;
   logic wr_flags0;
   logic wr_flags1;
   logic wr_en0;
   logic wr_en1;

   // Address decode of the host register port
   always_comb begin
      wr_flags0 = 1'b0;
      wr_flags1 = 1'b0;
      wr_en0 = 1'b0;
      wr_en1 = 1'b0;
      if (reg_wr_in) begin
         case (reg_addr_in)
            `RIRQ_ADDR_FLAGS0: begin
               wr_flags0 = 1'b1;
            end
            `RIRQ_ADDR_FLAGS1: begin
               wr_flags1 = 1'b1;
            end
            `RIRQ_ADDR_EN0: begin
               wr_en0 = 1'b1;
            end
            `RIRQ_ADDR_EN1: begin
               wr_en1 = 1'b1;
            end
            default: begin
               // Error status and unmapped addresses ignore writes
            end
         endcase
      end
   end

   // Error status: hardware set beats hardware clear
   always_comb begin
      next_err = (err & ~err_clr_in) | err_set_in;
      err_event = |(err_set_in & ~err & `RIRQ_ERR_EVT_MASK);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err <= `RIRQ_RST_BYTE;
      end else begin
         err <= next_err;
      end
   end

   // First bank: engine events plus derived error event
   assign bank0.wr = wr_flags0;
   assign bank0.set_mode = reg_wdata_in[`RIRQ_SET_BIT];
   assign bank0.sel = reg_wdata_in[`RIRQ_B0_W-1:0];
   assign bank0.evt = {
      fill_high_event_in,
      fill_low_event_in,
      idle_event_in,
      tx_done_event_in,
      rx_done_event_in,
      err_event,
      rx_sof_event_in
   };

   // Second bank: card detect over five timer underflows
   assign bank1.wr = wr_flags1;
   assign bank1.set_mode = reg_wdata_in[`RIRQ_SET_BIT];
   assign bank1.sel = reg_wdata_in[`RIRQ_B1_W-1:0];
   assign bank1.evt = {
      card_presence_event_in,
      timer_underflow_in
   };

   rirq_flag_bank #(.W(`RIRQ_B0_W)) u_bank0 (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .bus(bank0.bank)
   );

   rirq_flag_bank #(.W(`RIRQ_B1_W)) u_bank1 (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .bus(bank1.bank)
   );

   // Enable registers are plain read/write bytes
   always_comb begin
      next_en0 = en0;
      next_en1 = en1;
      if (wr_en0) begin
         next_en0 = reg_wdata_in;
      end
      if (wr_en1) begin
         next_en1 = reg_wdata_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         en0 <= `RIRQ_RST_BYTE;
         en1 <= `RIRQ_RST_BYTE;
      end else begin
         en0 <= next_en0;
         en1 <= next_en1;
      end
   end

   // Global flag comes from registered state, so a flag read is self-consistent
   always_comb begin
      global_flag =
         (|(bank0.flags & en0[`RIRQ_B0_W-1:0])) |
         (|(bank1.flags & en1[`RIRQ_B1_W-1:0]));
   end

   // Pin drive from registered state only
   always_comb begin
      gated_req = global_flag & en1[`RIRQ_PIN_GATE_BIT];
      next_pin = gated_req ^ en0[`RIRQ_INV_BIT];
      if (en1[`RIRQ_DRIVE_BIT]) begin
         next_pin_oe_n = 1'b0;
      end else begin
         next_pin_oe_n = ~gated_req;
      end
   end

   // Registered so the pad never sees a decode glitch
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_pin_out <= 1'b0;
         irq_pin_oe_n_out <= 1'b1;
      end else begin
         irq_pin_out <= next_pin;
         irq_pin_oe_n_out <= next_pin_oe_n;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      next_rdata = reg_rdata_out;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `RIRQ_ADDR_FLAGS0: begin
               next_rdata = {1'b0, bank0.flags};
            end
            `RIRQ_ADDR_FLAGS1: begin
               next_rdata = {1'b0, global_flag, bank1.flags};
            end
            `RIRQ_ADDR_EN0: begin
               next_rdata = en0;
            end
            `RIRQ_ADDR_EN1: begin
               next_rdata = en1;
            end
            `RIRQ_ADDR_ERR: begin
               next_rdata = err;
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   // Read data holds until the next read strobe
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // Pad level passes three flops before anything reads it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         irq_pin_level_out <= 1'b0;
      end else begin
         pin_meta <= irq_pin_in;
         pin_sync <= pin_meta;
         irq_pin_level_out <= pin_sync;
      end
   end
endmodule // rirq_top
